/* qbio_far_pins.sv */
`timescale 1ns/1ps
module qbio_far_pins
    import qbio_pkg::*;
(
    // design drive
    input wire logic [7:0] od_in,
    input wire logic [7:0] od_oe_n_in,
    input wire logic [7:0] hi_in,
    input wire logic [7:0] hi_oe_n_in,
    input wire logic [19:0] pd_in,
    // outside drive, low pulls down
    input wire logic [35:0] ext_in,
    // line levels
    output logic [7:0] od_out,
    output logic [7:0] hi_out,
    output logic [19:0] qp_out
);
    // no pull-up on port0: a released line follows the outside
    assign od_out = (od_oe_n_in & ext_in[7:0]) | (~od_oe_n_in & od_in);
    assign hi_out = (hi_oe_n_in & ext_in[15:8]) | (~hi_oe_n_in & hi_in);
    assign qp_out = ~pd_in & ext_in[35:16];
endmodule

/* qbio_pkg.sv */
package qbio_pkg;

    // ------------------------------------------------------------
    // special-function addresses of the port latches
    // ------------------------------------------------------------
    localparam logic [7:0] QBIO_ADDR_PORT0 = 8'h80;
    localparam logic [7:0] QBIO_ADDR_PORT1 = 8'h90;
    localparam logic [7:0] QBIO_ADDR_PORT2 = 8'ha0;
    localparam logic [7:0] QBIO_ADDR_PORT3 = 8'hb0;
    localparam logic [7:0] QBIO_ADDR_PORT4 = 8'hd8;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int QBIO_WIDE = 8;
    localparam int QBIO_NIBBLE = 4;
    localparam int QBIO_BIT_IDX_W = 3;
    localparam logic [7:0] QBIO_LATCH_RESET = 8'hff;
    localparam logic [7:0] QBIO_NIBBLE_MASK = 8'h0f;
    localparam logic [7:0] QBIO_ZERO = 8'h00;

    // ------------------------------------------------------------
    // port selector and access command
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        QBIO_SEL_P0,
        QBIO_SEL_P1,
        QBIO_SEL_P2,
        QBIO_SEL_P3,
        QBIO_SEL_P4,
        QBIO_SEL_NONE
    } qbio_sel_e;

    typedef struct packed {
        logic byte_wr;
        logic bit_wr;
        logic rd_latch;
        logic [7:0] addr;
        logic [2:0] bit_idx;
        logic bit_val;
        logic [7:0] wdata;
    } qbio_sfr_s;

    typedef struct packed {
        logic active;
        logic drive_data;
        logic [7:0] low_addr_data;
        logic [7:0] upper_address_lines;
    } qbio_bus_s;

endpackage

/* qbio_ports.sv */
`timescale 1ns/1ps
// Operation
// - 36 lines: four byte ports, one nibble
// - latch zero turns pull-down on
// - latch one releases; weak pull-up except port0
// - reset sets latch0-3 to all ones, latch4 to 0f
// - port0 drives high only as bus
// - bus input forces port0 latch ones
// - port2 carries upper address during bus
// - bus ports mux latch or bus source
// - bus use: port0 latch ones, port2 kept
// - latches at sfr addresses, bit addressable
// - new latch value shown at instruction end
// - modify reads latch, plain read reads pins
module qbio_ports
    import qbio_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // sfr access
    input wire qbio_sfr_s sfr_in,
    input wire logic commit_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out,
    // external memory bus
    input wire qbio_bus_s bus_in,
    input wire logic external_access_select_n_in,
    output logic [7:0] bus_rdata_out,
    // pins
    input wire logic [7:0] open_drain_port_in,
    output logic [7:0] open_drain_port_out,
    output logic [7:0] open_drain_port_oe_n_out,
    input wire logic [7:0] quasi_port_one_in,
    output logic [7:0] quasi_port_one_pulldown_out,
    input wire logic [7:0] high_address_port_in,
    output logic [7:0] high_address_port_out,
    output logic [7:0] high_address_port_oe_n_out,
    input wire logic [7:0] quasi_port_three_in,
    output logic [7:0] quasi_port_three_pulldown_out,
    input wire logic [3:0] nibble_port_in,
    output logic [3:0] nibble_port_pulldown_out,
    // status
    output logic ext_mode_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic qbio_sel_e decode(input logic [7:0] addr);
        unique case (addr)
            QBIO_ADDR_PORT0: decode = QBIO_SEL_P0;
            QBIO_ADDR_PORT1: decode = QBIO_SEL_P1;
            QBIO_ADDR_PORT2: decode = QBIO_SEL_P2;
            QBIO_ADDR_PORT3: decode = QBIO_SEL_P3;
            QBIO_ADDR_PORT4: decode = QBIO_SEL_P4;
            default: decode = QBIO_SEL_NONE;
        endcase
    endfunction

    function automatic logic [7:0] apply(input logic [7:0] cur, input qbio_sfr_s req);
        logic [7:0] res;
        res = cur;
        if (req.byte_wr)
        begin
            res = req.wdata;
        end
        else if (req.bit_wr)
        begin
            res[req.bit_idx] = req.bit_val;
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // latch state
    // ------------------------------------------------------------
    logic [7:0] latch0, latch1, latch2, latch3, latch4;
    logic [7:0] next_latch0, next_latch1, next_latch2, next_latch3, next_latch4;
    logic ext_strap;
    logic next_ext_strap;
    logic strap_taken;
    logic next_strap_taken;
    logic [35:0] pins_sync;
    qbio_sel_e sel;
    logic bus_use;
    logic [7:0] pending;
    logic [7:0] next_pending;
    qbio_sel_e pend_sel;
    qbio_sel_e next_pend_sel;
    logic pend_valid;
    logic next_pend_valid;

    qbio_sync #(
        .WIDTH(36)
    ) u_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .async_in({nibble_port_in, quasi_port_three_in, high_address_port_in,
                   quasi_port_one_in, open_drain_port_in}),
        .sync_out(pins_sync)
    );

    assign sel = decode(sfr_in.addr);
    assign bus_use = bus_in.active | ext_strap;
    assign ext_mode_out = bus_use;

    always_comb
    begin
        next_ext_strap = ext_strap;
        next_strap_taken = 1'b1;
        next_pending = pending;
        next_pend_sel = pend_sel;
        next_pend_valid = pend_valid;
        next_latch0 = latch0;
        next_latch1 = latch1;
        next_latch2 = latch2;
        next_latch3 = latch3;
        next_latch4 = latch4;
        if (!strap_taken)
        begin
            next_ext_strap = ~external_access_select_n_in;
        end
        if (commit_in && pend_valid)
        begin
            next_pend_valid = 1'b0;
            unique case (pend_sel)
                QBIO_SEL_P0: next_latch0 = pending;
                QBIO_SEL_P1: next_latch1 = pending;
                QBIO_SEL_P2: next_latch2 = pending;
                QBIO_SEL_P3: next_latch3 = pending;
                default: next_latch4 = pending;
            endcase
        end
        // write staged, shown when the instruction's last cycle commits
        // a write in a commit cycle stays pending for the next commit
        if ((sfr_in.byte_wr | sfr_in.bit_wr) && sel != QBIO_SEL_NONE)
        begin
            unique case (sel)
                QBIO_SEL_P0: next_pending = apply(latch0, sfr_in);
                QBIO_SEL_P1: next_pending = apply(latch1, sfr_in);
                QBIO_SEL_P2: next_pending = apply(latch2, sfr_in);
                QBIO_SEL_P3: next_pending = apply(latch3, sfr_in);
                default: next_pending = apply(latch4, sfr_in) & QBIO_NIBBLE_MASK;
            endcase
            next_pend_sel = sel;
            next_pend_valid = 1'b1;
        end
        if (bus_use)
        begin
            next_latch0 = QBIO_LATCH_RESET;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            latch0 <= QBIO_LATCH_RESET;
            latch1 <= QBIO_LATCH_RESET;
            latch2 <= QBIO_LATCH_RESET;
            latch3 <= QBIO_LATCH_RESET;
            latch4 <= QBIO_NIBBLE_MASK;
            ext_strap <= 1'b0;
            strap_taken <= 1'b0;
            pending <= QBIO_ZERO;
            pend_sel <= QBIO_SEL_NONE;
            pend_valid <= 1'b0;
        end
        else
        begin
            latch0 <= next_latch0;
            latch1 <= next_latch1;
            latch2 <= next_latch2;
            latch3 <= next_latch3;
            latch4 <= next_latch4;
            ext_strap <= next_ext_strap;
            strap_taken <= next_strap_taken;
            pending <= next_pending;
            pend_sel <= next_pend_sel;
            pend_valid <= next_pend_valid;
        end
    end

    // ------------------------------------------------------------
    // sfr read: latch for modify, synchronised pins otherwise
    // ------------------------------------------------------------
    always_comb
    begin
        sfr_hit_out = (sel != QBIO_SEL_NONE);
        unique case (sel)
            QBIO_SEL_P0: sfr_rdata_out = sfr_in.rd_latch ? latch0 : pins_sync[7:0];
            QBIO_SEL_P1: sfr_rdata_out = sfr_in.rd_latch ? latch1 : pins_sync[15:8];
            QBIO_SEL_P2: sfr_rdata_out = sfr_in.rd_latch ? latch2 : pins_sync[23:16];
            QBIO_SEL_P3: sfr_rdata_out = sfr_in.rd_latch ? latch3 : pins_sync[31:24];
            QBIO_SEL_P4: sfr_rdata_out = sfr_in.rd_latch ? latch4 : {4'h0, pins_sync[35:32]};
            default: sfr_rdata_out = QBIO_ZERO;
        endcase
    end

    assign bus_rdata_out = pins_sync[7:0];

    // ------------------------------------------------------------
    // output stages; oe_n low while driving
    // ------------------------------------------------------------
    always_comb
    begin
        if (bus_use && bus_in.drive_data)
        begin
            // push-pull only while serving the bus
            open_drain_port_out = bus_in.low_addr_data;
            open_drain_port_oe_n_out = QBIO_ZERO;
        end
        else
        begin
            // open drain: only ever pulls low
            open_drain_port_out = QBIO_ZERO;
            open_drain_port_oe_n_out = latch0;
        end
        if (bus_use)
        begin
            high_address_port_out = bus_in.upper_address_lines;
            high_address_port_oe_n_out = QBIO_ZERO;
        end
        else
        begin
            high_address_port_out = QBIO_ZERO;
            high_address_port_oe_n_out = latch2;
        end
    end

    assign quasi_port_one_pulldown_out = ~latch1;
    assign quasi_port_three_pulldown_out = ~latch3;
    assign nibble_port_pulldown_out = ~latch4[3:0];

endmodule

/* qbio_ports_sva.sv */
`timescale 1ns/1ps
module qbio_ports_sva
    import qbio_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // watched ports
    input wire qbio_sfr_s sfr_in,
    input wire logic commit_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic sfr_hit_out,
    input wire qbio_bus_s bus_in,
    input wire logic [7:0] open_drain_port_out,
    input wire logic [7:0] quasi_port_one_pulldown_out,
    input wire logic [7:0] high_address_port_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    hit_map_a: assert property (sfr_hit_out == (sfr_in.addr inside {8'h80, 8'h90, 8'ha0,
        8'hb0, 8'hd8})) else $error("hit flag wrong");
    unmapped_zero_a: assert property (!sfr_hit_out |-> sfr_rdata_out == 8'h00)
        else $error("unmapped read");
    latch_read_a: assert property (sfr_in.rd_latch && sfr_in.addr == 8'h90
        |-> sfr_rdata_out == ~quasi_port_one_pulldown_out) else $error("latch read");
    commit_lands_a: assert property (sfr_in.byte_wr && sfr_in.addr == 8'h90
        ##1 commit_in && !sfr_in.byte_wr && !sfr_in.bit_wr
        |=> quasi_port_one_pulldown_out == ~$past(sfr_in.wdata, 2)) else $error("commit lost");
    nibble_top_a: assert property (sfr_in.addr == 8'hd8 |-> sfr_rdata_out[7:4] == 4'h0)
        else $error("nibble top");
    od_quiet_a: assert property (!bus_in.drive_data |-> open_drain_port_out == 8'h00)
        else $error("port0 drives");
    od_forced_a: assert property ($past(bus_in.active) && bus_in.active
        && sfr_in.rd_latch && sfr_in.addr == 8'h80 |-> sfr_rdata_out == 8'hff)
        else $error("port0 not forced");
    upper_addr_a: assert property (bus_in.active
        |-> high_address_port_out == bus_in.upper_address_lines) else $error("upper address");
endmodule
bind qbio_ports qbio_ports_sva qbio_ports_sva_i (.*);

/* qbio_sync.sv */
`timescale 1ns/1ps
module qbio_sync
    import qbio_pkg::*;
#(
    parameter int WIDTH = 36
)
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;

    // ------------------------------------------------------------
    // two-stage pin synchroniser
    // ------------------------------------------------------------
    always_comb
    begin
        next_stage1 = async_in;
        next_stage2 = stage1;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            stage1 <= '1;
            stage2 <= '1;
        end
        else
        begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_out = stage2;

endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import qbio_pkg::*;
;
    logic clock_in, rst_n_in, commit_in, sfr_hit_out, ext_mode_out, external_access_select_n_in;
    qbio_sfr_s sfr_in;
    qbio_bus_s bus_in;
    logic [7:0] sfr_rdata_out, bus_rdata_out, open_drain_port_in, open_drain_port_out, v;
    logic [7:0] open_drain_port_oe_n_out, high_address_port_in, high_address_port_out;
    logic [7:0] high_address_port_oe_n_out, quasi_port_one_pulldown_out;
    logic [7:0] quasi_port_three_pulldown_out, lat [5], adr [5];
    logic [3:0] nibble_port_pulldown_out;
    wire logic [7:0] quasi_port_one_in, quasi_port_three_in;
    wire logic [3:0] nibble_port_in;
    logic [35:0] ext;
    logic strap;
    int err_count, compares;
    qbio_ports qbio_ports_i (.*);
    qbio_far_pins qbio_far_pins_i (
        .od_in(open_drain_port_out), .od_oe_n_in(open_drain_port_oe_n_out), .ext_in(ext),
        .hi_in(high_address_port_out), .hi_oe_n_in(high_address_port_oe_n_out),
        .pd_in({nibble_port_pulldown_out, quasi_port_three_pulldown_out,
            quasi_port_one_pulldown_out}), .od_out(open_drain_port_in),
        .hi_out(high_address_port_in), .qp_out({nibble_port_in, quasi_port_three_in,
            quasi_port_one_in}));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic l, input logic [7:0] e);
        @(posedge clock_in);
        sfr_in.addr <= a;
        sfr_in.rd_latch <= l;
        #1;
        chk(sfr_rdata_out, e);
    endtask
    task automatic chk_all();
        for (int p = 0; p < 5; p++)
            rd(adr[p], 1'b1, lat[p]);
        chk(quasi_port_one_pulldown_out, ~lat[1]);
        chk(quasi_port_three_pulldown_out, ~lat[3]);
        chk({7'h0, ext_mode_out}, 8'h00);
        chk({4'h0, nibble_port_pulldown_out}, ~lat[4] & 8'h0f);
        chk(open_drain_port_oe_n_out, lat[0]);
        chk(high_address_port_oe_n_out, lat[2]);
    endtask
    task automatic wr(input int p, input logic b, input logic [2:0] i, input logic [7:0] d);
        @(posedge clock_in);
        sfr_in <= '{!b, b, 1'b0, adr[p], i, d[0], d};
        @(posedge clock_in);
        sfr_in <= '0;
        commit_in <= 1'b1;
        @(posedge clock_in);
        commit_in <= 1'b0;
        lat[p] = b ? lat[p] & ~(8'h01 << i) | 8'(d[0]) << i : d;
        lat[p] = (bus_in.active || strap) && p == 0 ? 8'hff : lat[p] & (p == 4 ? 8'h0f : 8'hff);
        if (!bus_in.active && !strap)
            chk_all();
    endtask
    task automatic complete_run();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial
    begin
        repeat (20000) @(posedge clock_in);
        err_count++;
        complete_run();
    end
    initial
    begin
        {rst_n_in, commit_in, sfr_in, bus_in} = '0;
        external_access_select_n_in = 1'b1;
        strap = 1'b0;
        ext = '1;
        lat = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h0f};
        adr = '{QBIO_ADDR_PORT0, QBIO_ADDR_PORT1, QBIO_ADDR_PORT2, QBIO_ADDR_PORT3,
            QBIO_ADDR_PORT4};
        void'($urandom(32'hf1df8a04));
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        chk_all();
        repeat (3)
            for (int p = 0; p < 5; p++)
                wr(p, 1'b0, 3'h0, 8'($urandom));
        for (int i = 0; i < 8; i++)
            wr(2, 1'b1, 3'(i), 8'($urandom));
        wr(0, 1'b0, 3'h0, 8'hff);
        wr(1, 1'b0, 3'h0, 8'hff);
        v = 8'($urandom);
        @(posedge clock_in);
        ext <= {12'hfff, ~v, 8'hff, v};
        repeat (3) @(posedge clock_in);
        rd(adr[1], 1'b0, ~v);
        chk(bus_rdata_out, v);
        rd(8'h85, 1'b0, 8'h00);
        chk({7'h0, sfr_hit_out}, 8'h00);
        @(posedge clock_in);
        bus_in <= '{1'b1, 1'b1, v, ~v};
        wr(0, 1'b0, 3'h0, 8'h00);
        rd(adr[0], 1'b1, 8'hff);
        chk({7'h0, ext_mode_out}, 8'h01);
        chk(high_address_port_out, ~v);
        chk(open_drain_port_out, v);
        rd(adr[2], 1'b1, lat[2]);
        @(posedge clock_in);
        bus_in <= '0;
        chk_all();
        // reset again with external access strapped low
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        external_access_select_n_in <= 1'b0;
        bus_in <= '{1'b0, 1'b0, 8'h00, v};
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        lat = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h0f};
        strap = 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        chk({7'h0, ext_mode_out}, 8'h01);
        chk(high_address_port_oe_n_out, 8'h00);
        chk(high_address_port_out, v);
        chk(open_drain_port_oe_n_out, 8'hff);
        chk(open_drain_port_out, 8'h00);
        wr(0, 1'b0, 3'h0, 8'h00);
        rd(adr[0], 1'b1, 8'hff);
        rd(adr[2], 1'b1, lat[2]);
        complete_run();
    end
endmodule
